// ==== rtl/analog_network_consts.vh ====
// analog_network_consts.vh - register map, field positions, reset values
// and divisor counts of the analog network control block.
// assumes a 32-bit apb slave where each register index takes one word.
`ifndef ANALOG_NETWORK_CONSTS_VH
`define ANALOG_NETWORK_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// register indexes, byte address is four times the index
`define IDX_IRQ_FLAGS        8'h06
`define IDX_IRQ_ENABLES      8'h07
`define IDX_RESULT_HIGH      8'h10
`define IDX_RESULT_LOW       8'h11
`define IDX_RESULT_EXTENSION 8'h12
`define IDX_CONVERTER_CTRL   8'h13
`define IDX_AMP_CLOCK_CTRL   8'h15
`define IDX_ROUTING_FIRST    8'h18
`define IDX_ROUTING_SECOND   8'h19
`define IDX_ENABLE_GAIN      8'h1a
`define IDX_AMP_ROUTING      8'h1b

////////////////////////////////////////////////////////////////////////////////
// reset values
`define RST_BYTE             8'h00

////////////////////////////////////////////////////////////////////////////////
// field positions
`define BIT_CONV_IRQ         2
`define BIT_GLOBAL_IRQ       7
`define BIT_FILTER_RUN       3
`define BIT_REF_DIV_ON       7
`define BIT_CONVERTER_ON     1
`define BIT_INPUT_SHORT      0
`define BIT_AMP2_ON          7
`define BIT_AMP1_ON          3

////////////////////////////////////////////////////////////////////////////////
// output-word rate divisors of the sample clock, per rate code
`define RATE_DIV_0           13'd125
`define RATE_DIV_1           13'd250
`define RATE_DIV_2           13'd500
`define RATE_DIV_3           13'd1000
`define RATE_DIV_4           13'd2000
`define RATE_DIV_5           13'd4000
`define RATE_DIV_6           13'd8000

////////////////////////////////////////////////////////////////////////////////
// chopper clock divisors of the core clock, per chopper field
`define CHOP_DIV_SLOW        13'd1000
`define CHOP_DIV_FAST        13'd500

`endif

// ==== rtl/step_divider.v ====
// step_divider.v - counts enabled steps and pulses once every divisor steps.
// assumes divisor is at least 1 and that the caller holds run high for a
// window; dropping run restarts the count from zero.
`timescale 1ns/10ps

module step_divider #(
	parameter WIDTH = 13
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire             ce,
	input  wire             run,
	input  wire             step,
	input  wire [WIDTH-1:0] divisor,
	output wire             tick
);

	reg [WIDTH-1:0] count_reg;
	reg [WIDTH-1:0] count_next;

	// tick marks the last step of a window
	assign tick = run & step & (count_reg >= divisor - {{(WIDTH-1){1'b0}}, 1'b1});

	// next count: hold, advance or wrap
	always @*
	begin
		count_next = count_reg;
		if (!run)
			count_next = {WIDTH{1'b0}};
		else if (tick)
			count_next = {WIDTH{1'b0}};
		else if (step)
			count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
	end

	// step counter
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_reg <= {WIDTH{1'b0}};
		else if (ce)
			count_reg <= count_next;
	end

endmodule // step_divider

// ==== rtl/analog_network_control.v ====
// analog_network_control.v - apb register file, decimating result path,
// chopper clock and interrupt of the analog network.
// assumes sample_tick comes from the sample clock generator on pclk and
// mod_bit comes straight from the modulator, outside the pclk domain.
//
// How it works
// - result 16 bits, two sign bits, 14 data
// - extension byte holds low byte of window ones count
// - filter runs only when run bit set, else zero
// - rate code divides sample clock, 110/111 by 8000
// - chopper field 11 divides by 1000, 10 by 500
// - field 01 minus offset, 00 plus offset, static
// - negative input select in routing one bits 7-6
// - negative reference select in routing two bits 3-2
// - positive reference select in routing two bits 1-0
// - amplifier one noninverting and inverting input selects
// - differential input and reference path selects exposed
// - amplifier one off when its enable clear
// - interrupt flag raised on every new result word
// - converter enable starts and stops the modulator
// - input short ties both converter inputs together
`timescale 1ns/10ps
`include "analog_network_consts.vh"

module analog_network_control (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        sample_tick,
	input  wire        mod_bit,
	output wire        irq,
	output wire [1:0]  neg_input_select,
	output wire [2:0]  prefilter_input_select,
	output wire [2:0]  pos_input_select,
	output wire [1:0]  neg_reference_select,
	output wire [1:0]  pos_reference_select,
	output wire [1:0]  amp1_inv_select,
	output wire [1:0]  amp2_inv_select,
	output wire [2:0]  amp1_noninv_select,
	output wire [2:0]  amp2_noninv_select,
	output wire        amp1_on,
	output wire        amp2_on,
	output wire        converter_on,
	output wire        input_short,
	output wire [1:0]  input_gain_code,
	output wire        reference_divider_on,
	output wire        modulator_run,
	output wire        amp1_chop_clock,
	output wire        amp1_polarity
);

	////////////////////////////////////////////////////////////////////////////
	// register storage
	reg        conv_irq_flag_reg;
	reg        conv_irq_mask_reg;
	reg        global_irq_mask_reg;
	reg [3:0]  converter_control_reg;
	reg [1:0]  amp1_chopper_field_reg;
	reg [7:0]  routing_first_reg;
	reg [7:0]  routing_second_reg;
	reg [4:0]  enable_gain_reg;
	reg [7:0]  amp_routing_reg;
	reg [15:0] conversion_result_reg;
	reg [7:0]  result_extension_reg;

	// result path state
	reg        mod_meta_reg;
	reg        mod_sync_reg;
	reg [14:0] window_sum_reg;
	reg [12:0] window_ones_reg;
	reg [14:0] window_sum_next;
	reg [12:0] window_ones_next;
	reg [12:0] rate_divisor;

	// chopper state
	reg        chop_clock_reg;
	reg        polarity_reg;
	reg        polarity_next;
	reg [12:0] chop_divisor;

	wire [7:0] reg_index;
	wire       word_aligned;
	wire       wr_en;
	wire       rd_en;
	reg        addr_hit;
	reg [7:0]  rd_byte;
	wire       filter_run;
	wire [2:0] output_rate_code;
	wire       window_run;
	wire       word_tick;
	wire       chop_run;
	wire       chop_tick;
	wire       conv_irq_set;

	////////////////////////////////////////////////////////////////////////////
	// apb decode: zero wait states, unmapped or misaligned access errors
	assign reg_index    = {2'b00, paddr[7:2]};
	assign word_aligned = (paddr[1:0] == 2'b00);
	assign pready       = 1'b1;
	assign pslverr      = psel & penable & ~addr_hit;
	assign wr_en        = psel & penable & pwrite & addr_hit;
	assign rd_en        = psel & penable & ~pwrite & addr_hit;

	// address decode and read mux
	always @*
	begin
		addr_hit = word_aligned;
		rd_byte  = 8'h00;
		if (reg_index == `IDX_IRQ_FLAGS)
			rd_byte = {5'h00, conv_irq_flag_reg, 2'h0};
		else if (reg_index == `IDX_IRQ_ENABLES)
			rd_byte = {global_irq_mask_reg, 4'h0, conv_irq_mask_reg, 2'h0};
		else if (reg_index == `IDX_RESULT_HIGH)
			rd_byte = conversion_result_reg[15:8];
		else if (reg_index == `IDX_RESULT_LOW)
			rd_byte = conversion_result_reg[7:0];
		else if (reg_index == `IDX_RESULT_EXTENSION)
			rd_byte = result_extension_reg;
		else if (reg_index == `IDX_CONVERTER_CTRL)
			rd_byte = {4'h0, converter_control_reg};
		else if (reg_index == `IDX_AMP_CLOCK_CTRL)
			rd_byte = {4'h0, amp1_chopper_field_reg, 2'h0};
		else if (reg_index == `IDX_ROUTING_FIRST)
			rd_byte = routing_first_reg;
		else if (reg_index == `IDX_ROUTING_SECOND)
			rd_byte = routing_second_reg;
		else if (reg_index == `IDX_ENABLE_GAIN)
			rd_byte = {enable_gain_reg[4], 3'h0, enable_gain_reg[3:0]};
		else if (reg_index == `IDX_AMP_ROUTING)
			rd_byte = amp_routing_reg;
		else
			addr_hit = 1'b0;
	end

	// registered read data, captured in the setup cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (ce && psel && !penable)
			prdata <= {24'h00_0000, rd_byte};
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers written by software
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			conv_irq_mask_reg      <= 1'b0;
			global_irq_mask_reg    <= 1'b0;
			converter_control_reg  <= 4'h0;
			amp1_chopper_field_reg <= 2'h0;
			routing_first_reg      <= `RST_BYTE;
			routing_second_reg     <= `RST_BYTE;
			enable_gain_reg        <= 5'h00;
			amp_routing_reg        <= `RST_BYTE;
		end
		else if (ce && wr_en)
		begin
			if (reg_index == `IDX_IRQ_ENABLES)
			begin
				conv_irq_mask_reg   <= pwdata[`BIT_CONV_IRQ];
				global_irq_mask_reg <= pwdata[`BIT_GLOBAL_IRQ];
			end
			else if (reg_index == `IDX_CONVERTER_CTRL)
				converter_control_reg <= pwdata[3:0];
			else if (reg_index == `IDX_AMP_CLOCK_CTRL)
				amp1_chopper_field_reg <= pwdata[3:2];
			else if (reg_index == `IDX_ROUTING_FIRST)
				routing_first_reg <= pwdata[7:0];
			else if (reg_index == `IDX_ROUTING_SECOND)
				routing_second_reg <= pwdata[7:0];
			else if (reg_index == `IDX_ENABLE_GAIN)
				enable_gain_reg <= {pwdata[`BIT_REF_DIV_ON], pwdata[3:0]};
			else if (reg_index == `IDX_AMP_ROUTING)
				amp_routing_reg <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// multiplexer codes and enables handed to the analog front end
	assign neg_input_select       = routing_first_reg[7:6];
	assign prefilter_input_select = routing_first_reg[5:3];
	assign pos_input_select       = routing_first_reg[2:0];
	assign amp2_inv_select        = routing_second_reg[7:6];
	assign amp1_inv_select        = routing_second_reg[5:4];
	assign neg_reference_select   = routing_second_reg[3:2];
	assign pos_reference_select   = routing_second_reg[1:0];
	assign reference_divider_on   = enable_gain_reg[4];
	assign input_gain_code        = enable_gain_reg[3:2];
	assign converter_on           = enable_gain_reg[`BIT_CONVERTER_ON];
	assign input_short            = enable_gain_reg[`BIT_INPUT_SHORT];
	assign amp2_on                = amp_routing_reg[`BIT_AMP2_ON];
	assign amp2_noninv_select     = amp_routing_reg[6:4];
	assign amp1_on                = amp_routing_reg[`BIT_AMP1_ON];
	assign amp1_noninv_select     = amp_routing_reg[2:0];
	assign modulator_run          = converter_on;

	////////////////////////////////////////////////////////////////////////////
	// modulator bit synchroniser
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mod_meta_reg <= 1'b0;
			mod_sync_reg <= 1'b0;
		end
		else if (ce)
		begin
			mod_meta_reg <= mod_bit;
			mod_sync_reg <= mod_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output-word rate selection
	assign filter_run       = converter_control_reg[`BIT_FILTER_RUN];
	assign output_rate_code = converter_control_reg[2:0];
	assign window_run       = filter_run & converter_on;

	always @*
	begin
		case (output_rate_code)
			3'h0:    rate_divisor = `RATE_DIV_0;
			3'h1:    rate_divisor = `RATE_DIV_1;
			3'h2:    rate_divisor = `RATE_DIV_2;
			3'h3:    rate_divisor = `RATE_DIV_3;
			3'h4:    rate_divisor = `RATE_DIV_4;
			3'h5:    rate_divisor = `RATE_DIV_5;
			default: rate_divisor = `RATE_DIV_6;
		endcase
	end

	step_divider #(
		.WIDTH   (13)
	) word_divider (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.run     (window_run),
		.step    (sample_tick),
		.divisor (rate_divisor),
		.tick    (word_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// single-stage comb: signed bit sum and ones count over one window
	always @*
	begin
		window_sum_next  = window_sum_reg;
		window_ones_next = window_ones_reg;
		if (window_run && sample_tick)
		begin
			if (mod_sync_reg)
			begin
				window_sum_next  = window_sum_reg + 15'h0001;
				window_ones_next = window_ones_reg + 13'h0001;
			end
			else
				window_sum_next = window_sum_reg - 15'h0001;
		end
	end

	// window accumulators restart at each word and whenever the filter stops
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			window_sum_reg  <= 15'h0000;
			window_ones_reg <= 13'h0000;
		end
		else if (ce)
		begin
			if (!window_run || word_tick)
			begin
				window_sum_reg  <= 15'h0000;
				window_ones_reg <= 13'h0000;
			end
			else
			begin
				window_sum_reg  <= window_sum_next;
				window_ones_reg <= window_ones_next;
			end
		end
	end

	// result bytes load together; the sum never exceeds 14 bits of magnitude,
	// so extending its sign fills both top bits
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			conversion_result_reg <= 16'h0000;
			result_extension_reg  <= 8'h00;
		end
		else if (ce)
		begin
			if (!filter_run)
			begin
				conversion_result_reg <= 16'h0000;
				result_extension_reg  <= 8'h00;
			end
			else if (word_tick)
			begin
				conversion_result_reg <= {window_sum_next[14], window_sum_next};
				result_extension_reg  <= window_ones_next[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt: sticky flag, write one to clear, set wins over clear
	assign conv_irq_set = word_tick & filter_run;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			conv_irq_flag_reg <= 1'b0;
		else if (ce)
		begin
			if (conv_irq_set)
				conv_irq_flag_reg <= 1'b1;
			else if (wr_en && reg_index == `IDX_IRQ_FLAGS && pwdata[`BIT_CONV_IRQ])
				conv_irq_flag_reg <= 1'b0;
		end
	end

	assign irq = conv_irq_flag_reg & conv_irq_mask_reg & global_irq_mask_reg;

	////////////////////////////////////////////////////////////////////////////
	// amplifier one chopper: half period counted in core clocks
	assign chop_run = amp1_on & amp1_chopper_field_reg[1];

	always @*
	begin
		if (amp1_chopper_field_reg[0])
			chop_divisor = `CHOP_DIV_SLOW >> 1;
		else
			chop_divisor = `CHOP_DIV_FAST >> 1;
	end

	step_divider #(
		.WIDTH   (13)
	) chop_divider (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.run     (chop_run),
		.step    (1'b1),
		.divisor (chop_divisor),
		.tick    (chop_tick)
	);

	// input polarity follows the chopper or the static offset choice
	always @*
	begin
		if (chop_run)
			polarity_next = chop_tick ? ~chop_clock_reg : chop_clock_reg;
		else
			polarity_next = amp1_chopper_field_reg[0];
	end

	// chopper clock stops low while chopping is off
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			chop_clock_reg <= 1'b0;
			polarity_reg   <= 1'b0;
		end
		else if (ce)
		begin
			if (!chop_run)
				chop_clock_reg <= 1'b0;
			else if (chop_tick)
				chop_clock_reg <= ~chop_clock_reg;
			polarity_reg <= polarity_next;
		end
	end

	assign amp1_chop_clock = chop_clock_reg;
	assign amp1_polarity   = polarity_reg;

endmodule // analog_network_control

// ==== tb/anc_checker.sv ====
// anc_checker.sv - port assertions for the analog network control block.
// assumes it is bound onto analog_network_control and that ce stays high.
`timescale 1ns/10ps

module anc_checker (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        irq,
	input wire        amp1_on,
	input wire        converter_on,
	input wire        modulator_run,
	input wire        amp1_chop_clock
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////////
	// cycles since the last rising chopper edge, armed after one full edge
	reg       chop_d_reg;
	reg       seen_reg;
	reg [9:0] gap_reg;
	wire      rise = amp1_chop_clock & ~chop_d_reg;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			chop_d_reg <= 1'b0;
			seen_reg   <= 1'b0;
			gap_reg    <= 10'h0;
		end
		else
		begin
			chop_d_reg <= amp1_chop_clock;
			seen_reg   <= amp1_on & (seen_reg | rise);
			gap_reg    <= rise ? 10'h0 : gap_reg + 10'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_run_follows: assert property (modulator_run == converter_on)
		else $error("modulator run differs from enable");
	a_chop_idle: assert property (!amp1_on [*2] |-> !amp1_chop_clock)
		else $error("chopper runs with amplifier off");
	a_chop_period: assert property (rise && seen_reg |->
		gap_reg == 10'h1f3 || gap_reg == 10'h3e7)
		else $error("chopper period wrong");
	a_err_in_access: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	a_err_misalign: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access not refused");
	a_err_mapped: assert property (psel && penable && paddr == 8'h40 |-> !pslverr)
		else $error("mapped access refused");
	a_rdata_hold: assert property (!psel |=> $stable(prdata))
		else $error("prdata moved while idle");
	a_rdata_upper: assert property (psel && penable |-> prdata[31:8] == 24'h0)
		else $error("prdata upper bits set");
	a_irq_cleared: assert property (psel && penable && pwrite && paddr == 8'h18
		&& pwdata[2] |=> !irq)
		else $error("irq stays after flag clear");
	a_irq_masked: assert property (psel && penable && pwrite && paddr == 8'h1c
		&& !pwdata[2] |=> !irq)
		else $error("irq stays after mask clear");

	// main scenarios reached
	c_irq: cover property ($rose(irq));
	c_chop: cover property (rise && seen_reg);
	c_err: cover property (pslverr);
endmodule // anc_checker

// ==== tb/front_end_model.sv ====
// front_end_model.sv - modulator side: sample pulses and a bit stream.
// assumes the bench picks the bit density through ones.
`timescale 1ns/10ps

module front_end_model (
	input  wire pclk,
	input  wire presetn,
	input  wire run,
	input  wire ones,
	output reg  sample_tick,
	output wire mod_bit
);
	// one pulse every second cycle while the modulator runs, still otherwise
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sample_tick <= 1'b0;
		else
			sample_tick <= run & ~sample_tick;
	end

	// constant density bit stream
	assign mod_bit = ones;
endmodule // front_end_model

// ==== tb/analog_network_control_tb.sv ====
// analog_network_control_tb.sv - self-checking bench of the control block.
// assumes a 10 MHz pclk and the front end model on the modulator side.
`timescale 1ns/10ps

module analog_network_control_tb;
	reg         pclk;
	reg         presetn;
	reg         psel;
	reg         penable;
	reg         pwrite;
	reg  [7:0]  paddr;
	reg  [31:0] pwdata;
	reg         ones;
	reg  [31:0] rd;
	reg         err;
	integer     err_count;
	integer     checks;
	integer     i;
	wire [31:0] prdata;
	wire        pready, pslverr, sample_tick, mod_bit, irq, amp1_on, amp2_on;
	wire        converter_on, input_short, reference_divider_on, modulator_run;
	wire        amp1_chop_clock, amp1_polarity;
	wire [1:0]  neg_input_select, neg_reference_select, pos_reference_select;
	wire [1:0]  amp1_inv_select, amp2_inv_select, input_gain_code;
	wire [2:0]  prefilter_input_select, pos_input_select;
	wire [2:0]  amp1_noninv_select, amp2_noninv_select;
	logic [15:0] divs [0:7] = '{16'h7d, 16'hfa, 16'h1f4, 16'h3e8, 16'h7d0,
		16'hfa0, 16'h1f40, 16'h1f40};
	logic [7:0]  regs [0:10] = '{8'h18, 8'h1c, 8'h40, 8'h44, 8'h48, 8'h4c,
		8'h54, 8'h60, 8'h64, 8'h68, 8'h6c};

	analog_network_control uut (.pclk, .presetn, .ce(1'b1), .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_tick,
		.mod_bit, .irq, .neg_input_select, .prefilter_input_select,
		.pos_input_select, .neg_reference_select, .pos_reference_select,
		.amp1_inv_select, .amp2_inv_select, .amp1_noninv_select,
		.amp2_noninv_select, .amp1_on, .amp2_on, .converter_on, .input_short,
		.input_gain_code, .reference_divider_on, .modulator_run,
		.amp1_chop_clock, .amp1_polarity);

	front_end_model fe (.pclk, .presetn, .run(modulator_run), .ones,
		.sample_tick, .mod_bit);

	////////////////////////////////////////////////////////////////////////////
	// shared tasks
	task chk(input string name, input [31:0] exp, input [31:0] got);
	begin
		checks = checks + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("MISMATCH %0s expected %h seen %h", name, exp, got);
		end
	end
	endtask

	// one apb transfer, held until pready is sampled high; the watchdog
	// bounds the wait; one idle edge follows so register outputs settle
	task apb(input w, input [7:0] a, input [31:0] d);
	begin
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	end
	endtask

	task rchk(input string name, input [7:0] a, input [31:0] exp);
	begin
		apb(1'b0, a, 32'h0);
		chk(name, exp, rd);
	end
	endtask

	task wait_irq;
		integer n;
	begin
		n = 0;
		while (irq !== 1'b1 && n < 20000)
		begin
			@(posedge pclk);
			n = n + 1;
		end
		chk("irq", 32'h1, {31'h0, irq});
		if (n == 20000)
			tally_and_finish;
	end
	endtask

	// measures one half period of the chopper clock
	task gap(input [31:0] exp);
		integer n;
		integer k;
		reg     prev;
	begin
		for (k = 0; k < 2; k = k + 1)
		begin
			n = 0;
			prev = amp1_chop_clock;
			while (amp1_chop_clock === prev && n < 2000)
			begin
				@(posedge pclk);
				n = n + 1;
			end
		end
		chk("chop half period", exp, n);
		if (n >= 2000)
			tally_and_finish;
	end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// scenarios
	task t_reset;
	begin
		for (i = 0; i < 11; i = i + 1)
			rchk("reset value", regs[i], 32'h0);
		$display("reset values done");
	end
	endtask

	task t_routing;
	begin
		apb(1'b1, 8'h60, 32'he9);
		apb(1'b1, 8'h64, 32'h6d);
		apb(1'b1, 8'h6c, 32'hd6);
		chk("neg input", 32'h3, neg_input_select);
		chk("prefilter", 32'h5, prefilter_input_select);
		chk("pos input", 32'h1, pos_input_select);
		chk("amp2 inv", 32'h1, amp2_inv_select);
		chk("amp1 inv", 32'h2, amp1_inv_select);
		chk("neg ref", 32'h3, neg_reference_select);
		chk("pos ref", 32'h1, pos_reference_select);
		chk("amp on", 32'h2, {amp2_on, amp1_on});
		chk("noninv", 32'h56, {amp2_noninv_select, 1'b0, amp1_noninv_select});
		rchk("routing first", 8'h60, 32'he9);
		rchk("routing second", 8'h64, 32'h6d);
		$display("routing done");
	end
	endtask

	task t_enable;
	begin
		apb(1'b1, 8'h68, 32'h8f);
		chk("enable gain", 32'h3f, {reference_divider_on, input_gain_code,
			converter_on, input_short, modulator_run});
		apb(1'b1, 8'h68, 32'h02);
		chk("short off", 32'h5, {converter_on, input_short, modulator_run});
		$display("enables done");
	end
	endtask

	task t_chop;
	begin
		apb(1'b1, 8'h6c, 32'h08);
		apb(1'b1, 8'h54, 32'h08);
		gap(32'hfa);
		apb(1'b1, 8'h6c, 32'h00);
		repeat (600) @(posedge pclk);
		chk("chop off", 32'h0, amp1_chop_clock);
		apb(1'b1, 8'h54, 32'h0c);
		apb(1'b1, 8'h6c, 32'h08);
		gap(32'h1f4);
		apb(1'b1, 8'h54, 32'h04);
		repeat (3) @(posedge pclk);
		chk("minus offset", 32'h1, {amp1_chop_clock, amp1_polarity});
		apb(1'b1, 8'h54, 32'h00);
		repeat (3) @(posedge pclk);
		chk("plus offset", 32'h0, {amp1_chop_clock, amp1_polarity});
		$display("chopper done");
	end
	endtask

	// each rate code with a full-scale stream, then a negative word
	task t_conv;
	begin
		apb(1'b1, 8'h1c, 32'h84);
		for (i = 0; i < 9; i = i + 1)
		begin
			ones <= (i < 8);
			apb(1'b1, 8'h4c, i % 8);
			apb(1'b1, 8'h18, 32'h04);
			apb(1'b1, 8'h4c, 32'h08 | (i % 8));
			wait_irq;
			if (i < 8)
			begin
				rchk("result high", 8'h40, divs[i] >> 8);
				rchk("result low", 8'h44, divs[i] & 16'hff);
				rchk("result ext", 8'h48, divs[i] & 16'hff);
			end
		end
		rchk("negative high", 8'h40, 32'hff);
		rchk("negative low", 8'h44, 32'h83);
		rchk("negative ext", 8'h48, 32'h00);
		apb(1'b1, 8'h44, 32'h55);
		rchk("read only low", 8'h44, 32'h83);
		apb(1'b1, 8'h1c, 32'h00);
		apb(1'b1, 8'h18, 32'h04);
		repeat (300) @(posedge pclk);
		chk("masked irq", 32'h0, irq);
		rchk("flag", 8'h18, 32'h04);
		apb(1'b1, 8'h4c, 32'h00);
		rchk("filter off", 8'h44, 32'h0);
		$display("conversion done");
	end
	endtask

	task t_bus;
	begin
		apb(1'b1, 8'h70, 32'hff);
		chk("unmapped err", 32'h1, err);
		apb(1'b0, 8'h42, 32'h0);
		chk("misaligned err", 32'h1, err);
		apb(1'b1, 8'h40, 32'h55);
		rchk("read only", 8'h40, 32'h0);
		$display("bus errors done");
	end
	endtask

	task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// clock, watchdog and main sequence
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	initial
	begin
		#9000000;
		err_count = err_count + 1;
		tally_and_finish;
	end

	initial
	begin
		err_count = 0;
		checks = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, ones} = 4'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_routing;
		t_enable;
		t_chop;
		t_conv;
		t_bus;
		tally_and_finish;
	end
endmodule // analog_network_control_tb

bind analog_network_control anc_checker port_checker (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
	.amp1_on, .converter_on, .modulator_run, .amp1_chop_clock);
